// file: verilog/stage_pkg.sv
// Shared constants and types for the staging and target queue block
package stage_pkg;
  localparam int unsigned DATA_W      = 32;
  localparam int unsigned QUEUE_DEPTH = 8;
  localparam int unsigned SLOT_COUNT  = 14;
  localparam int unsigned RAMP_COUNT  = 13;
  // Skip counter width and reset values
  localparam int unsigned SKIP_W      = 4;
  localparam logic [3:0]  SKIP_RST    = 4'h0;
  localparam int unsigned SKIP_FIELD_LSB = 20;
  localparam int unsigned START_EN_BIT   = 4;
  localparam logic [31:0] WORD_RST    = 32'h0000_0000;
  // Curve settle time in clock periods
  localparam int unsigned CURVE_SETTLE_CYC = 320;
  localparam int unsigned SETTLE_W    = 9;
  // Ramp parameter index order inside the active bank
  localparam int unsigned R_PEAK_VELOCITY = 0;
  localparam int unsigned R_PEAK_ACCEL = 1;
  localparam int unsigned R_PEAK_DECEL = 2;
  localparam int unsigned R_ASTART = 3;
  localparam int unsigned R_DFINAL = 4;
  localparam int unsigned R_VBREAK = 5;
  localparam int unsigned R_VSTART = 6;
  localparam int unsigned R_VSTOP = 7;
  localparam int unsigned R_CURVE_JERK_FIRST = 8;
  localparam int unsigned R_BOW2 = 9;
  localparam int unsigned R_BOW3 = 10;
  localparam int unsigned R_BOW4 = 11;
  localparam int unsigned R_RMODE = 12;
  // Destination indices of the target queue
  localparam int unsigned D_GOAL = 0;
  localparam int unsigned D_COMP = 1;
  localparam int unsigned D_SCALE = 2;
  localparam int unsigned D_GCONF = 3;

  typedef enum logic [1:0] {
    SH_FULL  = 2'b00,
    SH_SCURV = 2'b01,
    SH_TRAP  = 2'b10,
    SH_TRAP2 = 2'b11
  } shadow_opt_t;
endpackage : stage_pkg

// file: verilog/queue_segment.sv
// One segment of the target queue: shift and write-back
`timescale 1ns/1ps
`default_nettype none
module queue_segment (
  input  wire logic [7:0]  segMask,
  input  wire logic        advance,
  input  wire logic [7:0]  rewriteSel,
  input  wire logic [31:0] destValue,
  input  wire logic [31:0] inEntry [8],
  output logic      [31:0] outEntry [8]
);
  // Entries in the mask take successor within the segment; the last takes nothing new
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      outEntry[i] = inEntry[i];
      if (advance && segMask[i]) begin
        if (i < 7 && segMask[(i < 7) ? i + 1 : 7]) begin
          outEntry[i] = inEntry[(i < 7) ? i + 1 : 7];
        end
        if (rewriteSel[i]) begin
          outEntry[i] = destValue;  // Write-back wins over the shift
        end
      end
    end
  end
endmodule : queue_segment
`default_nettype wire

// file: verilog/shadow_and_target_pipeline.sv
// Staging bank transfer and segmented target queue of the ramp controller
//
// Behaviour
// [RULE1] Parameters outside the chosen staging set keep their values across transfers.
// [RULE2] Without cyclic mode the last staging stage holds its values after transfer.
// [RULE3] A skip count up to 15 start signals may be set.
// [RULE4] With skip N, N starts are ignored and start N+1 transfers, repeating.
// [RULE5] The running skip counter is readable in bits 23:20 of start config.
// [RULE6] Transfers need start enable bit 4 and at least one trigger source.
// [RULE7] Host waits 320 clocks after curve writes before any transfer.
// [RULE8] Each start loads the goal from entry 0 and shifts entries down.
// [RULE9] Four enable bits pick goal, compare, scale factor and global config.
// [RULE10] Set write-back bits copy destination values into selected queue entries.
// [RULE11] The eight entries split into up to four segments for four destinations.
// [RULE12] Host should update close compare values right after start, or queue them.
// [RULE13] Option field picks full, S-curve double, or trapezoidal double stage sets.
// [RULE14] Cyclic mode writes active parameters back into the last staging stage.
// [RULE15] Segment heads follow the enabled count: 0; 0,4; 0,3,6; 0,2,4,6.
// [RULE16] Transfer and queue shift from one start update in the same cycle.
`timescale 1ns/1ps
`default_nettype none
module shadow_and_target_pipeline (
  input  wire logic                   mclk,
  input  wire logic                   sys_rst,
  input  wire logic                   startPulse,
  input  wire logic                   startEnable,
  input  wire logic [3:0]             triggerSelect,
  input  wire logic [1:0]             shadowOption,
  input  wire logic                   cyclicShadow,
  input  wire logic [3:0]             skip_count_setting,
  input  wire logic [3:0]             queueEnable,
  input  wire logic [7:0]             queue_writeback_select,
  input  wire logic                   hostWrite,
  input  wire logic [1:0]             hostTarget,
  input  wire logic [3:0]             hostIndex,
  input  wire logic [31:0]            hostData,
  output logic      [3:0]             skip_count_running,
  output logic                        staging_apply_pulse,
  output logic                        curveSettling,
  output logic      [31:0]            rampValue [stage_pkg::RAMP_COUNT],
  output logic      [31:0]            slotValue [stage_pkg::SLOT_COUNT],
  output logic      [31:0]            queueValue [stage_pkg::QUEUE_DEPTH],
  output logic      [31:0]            position_goal,
  output logic      [31:0]            compareValue,
  output logic      [31:0]            follower_scale_factor,
  output logic      [31:0]            global_config_reg
);
  import stage_pkg::*;

  // *****************************************************
  // Host write targets: 0 ramp, 1 staging, 2 queue, 3 destination
  // *****************************************************
  // Whole state in one struct: transfer and queue shift land on one edge
  typedef struct packed {
    logic [RAMP_COUNT-1:0][31:0]  ramp;
    logic [SLOT_COUNT-1:0][31:0]  slot;
    logic [QUEUE_DEPTH-1:0][31:0] queue;
    logic [3:0][31:0]             dest;
    logic [3:0]                   skip;
    logic                         apply;
    logic [8:0]                   settle;
  } state_t;

  state_t s_q;
  state_t s_d;

  // Transfer qualifier and skip decision
  // Refused starts move nothing: no count, no shift, no write-back
  logic startOk;
  logic doApply;
  assign startOk = startPulse && startEnable && (|triggerSelect);  // see [RULE6]
  assign doApply = startOk && (s_q.skip == skip_count_setting);     // see [RULE4]

  // *****************************************************
  // Segment layout from the enabled destinations
  // *****************************************************
  logic [3:0][7:0] segMask;
  logic [3:0][2:0] segHead;
  always_comb begin
    int n;
    logic [2:0] nEn;
    n = 0;
    // Count widened first; a one-bit sum would fold two destinations into zero
    nEn = 3'(queueEnable[0]) + 3'(queueEnable[1]) + 3'(queueEnable[2]) + 3'(queueEnable[3]);
    segMask = '0;
    segHead = '0;
    for (int d = 0; d < 4; d++) begin
      if (queueEnable[d]) begin  // see [RULE9]
        unique case (nEn)
          3'd1: begin
            segHead[d] = 3'd0;  // One eight-entry segment
            segMask[d] = 8'hFF;
          end
          3'd2: begin
            segHead[d] = 3'(4 * n);
            segMask[d] = 8'h0F << (4 * n);
          end
          3'd3: begin
            segHead[d] = 3'(3 * n);  // see [RULE15]
            segMask[d] = (n == 2) ? 8'hC0 : (8'h07 << (3 * n));
          end
          default: begin
            segHead[d] = 3'(2 * n);
            segMask[d] = 8'h03 << (2 * n);
          end
        endcase
        n = n + 1;
      end
    end
  end

  // *****************************************************
  // Target queue segments
  // *****************************************************
  // Each segment shifts its own entries; chained so all update together
  logic [31:0] chain [5][8];
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      chain[0][i] = s_q.queue[i];
    end
  end
  for (genvar g = 0; g < 4; g++) begin : gSeg
    queue_segment uSeg (
      .segMask    (queueEnable[g] ? segMask[g] : 8'h00),  // see [RULE11]
      .advance    (startOk),                               // see [RULE8]
      .rewriteSel (queue_writeback_select),               // see [RULE10]
      .destValue  (s_q.dest[g]),
      .inEntry    (chain[g]),
      .outEntry   (chain[g+1])
    );
  end

  // *****************************************************
  // Next state
  // *****************************************************
  always_comb begin
    s_d = s_q;
    s_d.apply = doApply;
    // Skip counter runs on every qualified start
    // A refused start cannot advance it, so the skip pattern never slips
    if (startOk) begin
      s_d.skip = doApply ? SKIP_RST : s_q.skip + 4'h1;  // see [RULE3]
    end
    // Staging transfer, untouched ramp entries hold  see [RULE1]
    if (doApply) begin  // see [RULE16]
      unique case (shadowOption)  // see [RULE13]
        SH_FULL: begin
          for (int r = 0; r < RAMP_COUNT; r++) begin
            s_d.ramp[r] = s_q.slot[r];
            if (cyclicShadow) s_d.slot[r] = s_q.ramp[r];  // see [RULE14]
          end
        end
        default: begin
          int map [7];
          // Double stage: first stage to the ramp set, second stage moves up
          map = '{R_PEAK_VELOCITY, R_PEAK_ACCEL, R_PEAK_DECEL, R_CURVE_JERK_FIRST, R_BOW2, R_BOW3, R_BOW4};
          if (shadowOption != SH_SCURV) begin
            map = '{R_PEAK_VELOCITY, R_PEAK_ACCEL, R_PEAK_DECEL, R_ASTART, R_DFINAL, R_VBREAK,
                    (shadowOption == SH_TRAP) ? R_VSTART : R_VSTOP};
          end
          for (int k = 0; k < 7; k++) begin
            s_d.ramp[map[k]] = s_q.slot[k];
            s_d.slot[k] = s_q.slot[k + 7];
            // Last stage kept unless cyclic  see [RULE2]
            if (cyclicShadow) s_d.slot[k + 7] = s_q.ramp[map[k]];  // see [RULE14]
          end
        end
      endcase
    end
    // Queue shift and destination feed in the same edge
    // Feeds read entries before the shift, so a head never sees its successor
    for (int i = 0; i < 8; i++) begin
      s_d.queue[i] = chain[4][i];
    end
    for (int d = 0; d < 4; d++) begin
      if (startOk && queueEnable[d]) s_d.dest[d] = s_q.queue[segHead[d]];  // see [RULE8]
    end
    // Settle counter flags the curve calculation window
    // A later staging write restarts it; the host then just waits longer
    if (s_q.settle != 9'h000) s_d.settle = s_q.settle - 9'h001;
    // Host writes last; a start in the same cycle is overridden only at that word
    if (hostWrite) begin
      unique case (hostTarget)
        2'd0: if (hostIndex < RAMP_COUNT) s_d.ramp[hostIndex] = hostData;
        2'd1: begin
          if (hostIndex < SLOT_COUNT) s_d.slot[hostIndex] = hostData;
          s_d.settle = 9'(CURVE_SETTLE_CYC);  // see [RULE7]
        end
        2'd2: if (hostIndex < QUEUE_DEPTH) s_d.queue[hostIndex[2:0]] = hostData;
        2'd3: s_d.dest[hostIndex[1:0]] = hostData;
      endcase
    end
  end

  // Single register bank
  // Synchronous clear of every word, so outputs read zero right after release
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // *****************************************************
  // Outputs
  // *****************************************************
  assign skip_count_running    = s_q.skip;  // see [RULE5]
  assign staging_apply_pulse   = s_q.apply;
  assign curveSettling         = (s_q.settle != 9'h000);
  assign position_goal         = s_q.dest[D_GOAL];
  assign compareValue          = s_q.dest[D_COMP];
  assign follower_scale_factor = s_q.dest[D_SCALE];
  assign global_config_reg     = s_q.dest[D_GCONF];
  // Arrays are taps on the bank itself; no added stage, no added latency
  always_comb begin
    for (int r = 0; r < RAMP_COUNT; r++) rampValue[r] = s_q.ramp[r];
    for (int k = 0; k < SLOT_COUNT; k++) slotValue[k] = s_q.slot[k];
    for (int i = 0; i < QUEUE_DEPTH; i++) queueValue[i] = s_q.queue[i];
  end
endmodule : shadow_and_target_pipeline
`default_nettype wire

// file: testbench/stage_checker.sv
// Concurrent checks on the ports of the staging and target queue block
`timescale 1ns/1ps
`default_nettype none
module stage_checker (
  input wire logic        mclk,
  input wire logic        sys_rst,
  input wire logic        startPulse,
  input wire logic        startEnable,
  input wire logic [3:0]  triggerSelect,
  input wire logic [1:0]  shadowOption,
  input wire logic        cyclicShadow,
  input wire logic [3:0]  skip_count_setting,
  input wire logic [3:0]  queueEnable,
  input wire logic [7:0]  queue_writeback_select,
  input wire logic        hostWrite,
  input wire logic [1:0]  hostTarget,
  input wire logic [3:0]  skip_count_running,
  input wire logic        staging_apply_pulse,
  input wire logic        curveSettling,
  input wire logic [31:0] rampValue [stage_pkg::RAMP_COUNT],
  input wire logic [31:0] slotValue [stage_pkg::SLOT_COUNT],
  input wire logic [31:0] queueValue [stage_pkg::QUEUE_DEPTH],
  input wire logic [31:0] position_goal
);
  import stage_pkg::*;
  // Accepted start without a colliding host write, and the applying one
  logic take;
  logic go;
  assign take = startPulse && startEnable && |triggerSelect && !hostWrite;
  assign go = take && skip_count_running == skip_count_setting;
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  property p_off; !(startPulse && startEnable && |triggerSelect) |=> !staging_apply_pulse; endproperty
  a_off: assert property (p_off) else $error("apply without enabled start");
  property p_skip; take && skip_count_running != skip_count_setting
    |=> skip_count_running == $past(skip_count_running) + 4'h1 && !staging_apply_pulse; endproperty
  a_skip: assert property (p_skip) else $error("skipped start miscounted");
  property p_go; go |=> staging_apply_pulse && skip_count_running == 4'h0; endproperty
  a_go: assert property (p_go) else $error("transfer start not applied");
  property p_gl; take && queueEnable == 4'h1 |=> position_goal == $past(queueValue[0]); endproperty
  a_gl: assert property (p_gl) else $error("goal not fed from entry zero");
  property p_wb; take && queueEnable == 4'h1 && queue_writeback_select == 8'h10
    |=> queueValue[4] == $past(position_goal); endproperty
  a_wb: assert property (p_wb) else $error("goal not written back");
  property p_kp; take && shadowOption == SH_SCURV
    |=> rampValue[R_VSTART] == $past(rampValue[R_VSTART]); endproperty
  a_kp: assert property (p_kp) else $error("unselected parameter changed");
  property p_hd; go && !cyclicShadow && shadowOption != SH_FULL
    |=> slotValue[7] == $past(slotValue[7]) && slotValue[0] == $past(slotValue[7]); endproperty
  a_hd: assert property (p_hd) else $error("last stage not held");
  property p_cy; go && cyclicShadow && shadowOption == SH_SCURV
    |=> slotValue[7] == $past(rampValue[R_PEAK_VELOCITY]); endproperty
  a_cy: assert property (p_cy) else $error("active value not cycled back");
  // Settle flag must cover the whole curve window after a staging write
  property p_st; hostWrite && hostTarget == 2'h1
    |=> curveSettling ##300 curveSettling ##19 curveSettling; endproperty
  a_st: assert property (p_st) else $error("curve settle window too short");
endmodule : stage_checker
bind shadow_and_target_pipeline stage_checker i_chk (.*);
`default_nettype wire

// file: testbench/host_model.sv
// Behavioural host that writes parameters into the block
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic        mclk,
  input  wire logic        curveSettling,
  output logic             hostWrite = 1'b0,
  output logic      [1:0]  hostTarget = 2'h0,
  output logic      [3:0]  hostIndex = 4'h0,
  output logic      [31:0] hostData = 32'h0
);
  // One strobe held a cycle; released data is inverted so it is never stale
  task automatic wr(input logic [1:0] t, input logic [3:0] i, input logic [31:0] d, input int gap);
    repeat (gap) @(posedge mclk);
    @(posedge mclk);
    hostWrite <= 1'b1;
    hostTarget <= t;
    hostIndex <= i;
    hostData <= d;
    @(posedge mclk);
    hostWrite <= 1'b0;
    hostData <= ~d;
  endtask : wr
  // Hold off starts while curve values are absorbed, bounded wait
  // Polled mid-cycle so the flag's own edge never races the poll
  task automatic settle;
    @(negedge mclk);
    for (int n = 0; n < 400 && curveSettling !== 1'b0; n++) @(negedge mclk);
    @(posedge mclk);
  endtask : settle
endmodule : host_model
`default_nettype wire

// file: testbench/tb_top.sv
// Self-checking bench for the staging and target queue block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import stage_pkg::*;
  logic mclk = 1'b0, sys_rst = 1'b1, startPulse = 1'b0, startEnable = 1'b0, cyclicShadow = 1'b0;
  logic [3:0] triggerSelect = 4'h0, skip_count_setting = 4'h0, queueEnable = 4'h0, hostIndex;
  logic [1:0] shadowOption = 2'h0, hostTarget;
  logic [7:0] queue_writeback_select = 8'h00;
  logic hostWrite, staging_apply_pulse, curveSettling;
  logic [3:0] skip_count_running;
  logic [31:0] hostData, position_goal, compareValue, follower_scale_factor, global_config_reg;
  logic [31:0] rampValue [RAMP_COUNT], slotValue [SLOT_COUNT], queueValue [QUEUE_DEPTH];
  logic [31:0] v, ent [8], dOut [4], dst [4] = '{default: 32'h0};
  logic [3:0] skips [4] = '{4'h0, 4'h1, 4'hF, 4'h2};
  logic [3:0] pats [5] = '{4'h1, 4'h1, 4'h3, 4'h7, 4'hF};
  logic [159:0] nt, notes [$];
  int errors = 0, n_compared = 0, cyc = 0, k, hd;
  assign dOut = '{position_goal, compareValue, follower_scale_factor, global_config_reg};
  initial forever #4 mclk = ~mclk;
  shadow_and_target_pipeline i_dut (.*);
  host_model i_host (.*);
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp
  task automatic finish_test;
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test
  task automatic strt;
    @(posedge mclk) startPulse <= 1'b1;
    @(posedge mclk) startPulse <= 1'b0;
  endtask : strt
  // Each applied start consumes the oldest note; a surplus apply is a mismatch
  // Sampled mid-cycle, clear of the edge that launches the pulse
  always @(negedge mclk) if (staging_apply_pulse === 1'b1) begin
    if (notes.size() == 0) cmp("apply", 32'h0, 32'h1);
    else begin
      nt = notes.pop_front();
      cmp("peak_velocity", nt[159:128], rampValue[R_PEAK_VELOCITY]);
      for (int j = 0; j < 4; j++) cmp("dest", nt[32*j+:32], dOut[j]);
    end
  end
  // Hang guard, well above the expected run
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 6000) begin
      errors++;
      finish_test();
    end
  end
  // ******************************
  // Main sequence
  // ******************************
  initial begin
    void'($urandom(32'h64658388));
    repeat (12) @(posedge mclk);
    sys_rst <= 1'b0;
    startEnable <= 1'b1;
    // Every staging option, with skip counts 0, 1, 15 and 2
    for (int o = 0; o < 4; o++) begin
      @(posedge mclk) triggerSelect <= 4'h0;
      strt();
      v = $urandom;
      i_host.wr(2'h1, 4'h0, v, o);
      i_host.wr(2'h0, 4'(R_VSTART), $urandom, 0);
      i_host.settle();
      cmp("settle", 32'h0, 32'(curveSettling));
      shadowOption <= 2'(o);
      cyclicShadow <= (o < 2);
      skip_count_setting <= skips[o];
      triggerSelect <= 4'($urandom_range(15, 1));
      notes.push_back({v, dst[3], dst[2], dst[1], dst[0]});
      repeat (int'(skips[o]) + 1) strt();
    end
    // Queue split for one to four destinations; compare value is queued too
    i_host.wr(2'h1, 4'h0, v, 0);
    // Direct destination write; global config stays put until its queue is enabled
    i_host.wr(2'h3, 4'h3, v, 0);
    dst[3] = v;
    i_host.settle();
    cmp("settle", 32'h0, 32'(curveSettling));
    shadowOption <= 2'h0;
    skip_count_setting <= 4'h0;
    for (int p = 0; p < 5; p++) begin
      for (int e = 0; e < 8; e++) begin
        ent[e] = $urandom;
        i_host.wr(2'h2, 4'(e), ent[e], 0);
      end
      k = (p < 1) ? 1 : p;
      for (int j = 0; j < k; j++) begin
        hd = (k == 3) ? 3 * j : (8 / k) * j;
        dst[j] = ent[hd];
      end
      queueEnable <= pats[p];
      queue_writeback_select <= (p == 0) ? 8'h10 : (p == 1) ? 8'h00 : 8'($urandom);
      notes.push_back({v, dst[3], dst[2], dst[1], dst[0]});
      strt();
    end
    repeat (4) @(posedge mclk);
    cmp("notes", 32'h0, 32'(notes.size()));
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
